// *** logic/rts_top.sv ***
// Retirement tagging counters and precise sampling over APB.
// Assumes retirement and record memory signals run on pclk.
//
// Overview of operation
// [RQ1] Four independent marking schemes, one unmarked
// [RQ2] Front-end events marked, counted at retire
// [RQ3] Replay scheme marks replays and mispredicts
// [RQ4] Each scheme has its own detector
// [RQ5] Software enables one scheme when sampling
// [RQ6] Never mark IO, uncached, locked, returns, far
// [RQ7] Software sets front-end path select bits
// [RQ8] Upstream select names event and tag value
// [RQ9] Software sets upstream marking enable bit
// [RQ10] Selected tag bit set counts one
// [RQ11] Downstream enable and tag fields ignored
// [RQ12] Tag bit n pairs with mask n
// [RQ13] Several tag or mask bits combine
// [RQ14] Replay needs matrix, type and flag
// [RQ15] Replay tags also count without sampling
// [RQ16] Overflow copies state into a record
// [RQ17] After record, reload counter and resume
// [RQ18] Nearly full raises interrupt, no wrap
// [RQ19] Sampling only via counter four schemes
// [RQ20] Id query reports store facility bit
// [RQ21] Clear absent flag shows sampling present
// [RQ22] Enable bit and store area pointer
// [RQ23] Store disabled on mgmt mode, machine check
// [RQ24] Write at index, advance, then compare
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module rts_top (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Retiring micro-op
  input  wire logic         ret_valid,
  input  wire logic         ret_bogus,
  input  wire logic         ret_instr_end,
  input  wire logic         ret_no_mark,
  input  wire logic         ret_fe_event,
  input  wire logic [5:0]   ret_exec_class,
  input  wire logic [15:0]  ret_exec_mask,
  input  wire logic [7:0]   ret_replay_kind,
  input  wire logic [7:0]   ret_uop_type,
  input  wire logic         ret_mispredict,
  // Core events
  input  wire logic         smm_enter,
  input  wire logic         mcheck,
  input  wire logic         init_req,
  // Architectural state
  input  wire logic [255:0] gpr_flat,
  input  wire logic [31:0]  arith_flags,
  input  wire logic [31:0]  instr_ptr,
  // Record memory
  output logic              mem_valid,
  output logic [31:0]       mem_addr,
  output logic [31:0]       mem_wdata,
  input  wire logic         mem_ready,
  // Interrupt
  output logic              buf_irq
);
  function automatic logic any_sel(input logic [3:0] a,
                                   input logic [3:0] b);
    any_sel = |(a & b);
  endfunction : any_sel

  // Count on retired path or cancelled path as selected
  function automatic logic path_ok(input logic bogus,
                                   input logic sel_ret,
                                   input logic sel_can);
    path_ok = (~bogus & sel_ret) | (bogus & sel_can);
  endfunction : path_ok

  logic [31:0] sen_q, matrix_q, tcsel_q, upsel_q, dnsel_q, fesel_q;
  logic [31:0] cfg4_q, ctr4_q, reload_q, area_q, index_q;
  logic [31:0] thresh_q, absmax_q;
  logic [31:0] cnt_fe_q, cnt_ex_q, cnt_rp_q, cnt_in_q, cnt_uo_q;
  logic        irq_q, full_q, rd_err;
  logic [31:0] rd_data;
  logic        wr_busy, wr_done;

  // APB decode
  wire acc = psel & penable & ~pready;
  wire wr  = psel & penable & pready & pwrite;
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] o);
    hit = (a == o);
  endfunction : hit
  wire w_sen    = wr & hit(paddr, rts_pkg::RTS_OFS_SEN);
  wire w_matrix = wr & hit(paddr, rts_pkg::RTS_OFS_MATRIX);
  wire w_tcsel  = wr & hit(paddr, rts_pkg::RTS_OFS_TCSEL);
  wire w_upsel  = wr & hit(paddr, rts_pkg::RTS_OFS_UPSEL);
  wire w_dnsel  = wr & hit(paddr, rts_pkg::RTS_OFS_DNSEL);
  wire w_fesel  = wr & hit(paddr, rts_pkg::RTS_OFS_FESEL);
  wire w_cfg4   = wr & hit(paddr, rts_pkg::RTS_OFS_CFG4);
  wire w_ctr4   = wr & hit(paddr, rts_pkg::RTS_OFS_CTR4);
  wire w_reload = wr & hit(paddr, rts_pkg::RTS_OFS_RELOAD);
  wire w_area   = wr & hit(paddr, rts_pkg::RTS_OFS_AREA);
  wire w_index  = wr & hit(paddr, rts_pkg::RTS_OFS_INDEX);
  wire w_thresh = wr & hit(paddr, rts_pkg::RTS_OFS_THRESH);
  wire w_absmax = wr & hit(paddr, rts_pkg::RTS_OFS_ABSMAX);
  wire w_status = wr & hit(paddr, rts_pkg::RTS_OFS_STATUS);

  // [RQ6] Unmarkable micro-ops
  wire mark_ok = ret_valid & ~ret_no_mark;
  // [RQ2] Front-end marking and path select
  wire fe_tag  = mark_ok & ret_fe_event;
  wire fe_cnt  = fe_tag & path_ok(ret_bogus, fesel_q[0], fesel_q[1]);
  // [RQ8] Upstream match applies the tag value
  wire [3:0] up_tagval = upsel_q[rts_pkg::RTS_ESC_TAG_LO +: 4];
  wire [15:0] up_mask  = upsel_q[rts_pkg::RTS_ESC_MASK_LO +: 16];
  wire [5:0] up_class  = upsel_q[rts_pkg::RTS_ESC_SEL_LO +: 6];
  // [RQ9] Marking only with upstream enable set
  wire up_hit = upsel_q[rts_pkg::RTS_ESC_TAG_EN] & mark_ok &
                (ret_exec_class == up_class) &
                (|(ret_exec_mask & up_mask));
  wire [3:0] ex_tags = up_hit ? up_tagval : 4'h0;
  // [RQ11] Only the downstream mask field is used
  wire [15:0] dn_mask = dnsel_q[rts_pkg::RTS_ESC_MASK_LO +: 16];
  // [RQ12] Tag bit n matches mask bit n when retired, mask bit n+4 when cancelled
  // [RQ13] Any selected tag bit counts once
  wire ex_cnt = ret_valid &
                ((~ret_bogus & any_sel(ex_tags, dn_mask[3:0])) |
                 (ret_bogus & any_sel(ex_tags, dn_mask[7:4])));
  // [RQ3] Replay marking and mispredicted branches
  // [RQ14] Matrix type and replay kind both needed
  wire rp_tag = mark_ok &
                (((|(ret_replay_kind & sen_q[7:0])) &
                  (|(ret_uop_type & matrix_q[7:0]))) |
                 ret_mispredict);
  // [RQ15] Replay counting independent of sampling bits
  wire rp_cnt = rp_tag & ~ret_bogus;
  // [RQ1] Unmarked retired instruction and uop counts
  wire in_cnt = ret_valid & ~ret_bogus & ret_instr_end;
  wire uo_cnt = ret_valid & ~ret_bogus;

  // [RQ19] Counter four sampling on three schemes only
  wire [1:0] sch = cfg4_q[1:0];
  wire sch_ev = (sch == rts_pkg::RTS_SCH_FE)   ? fe_cnt :
                (sch == rts_pkg::RTS_SCH_EXEC) ? ex_cnt :
                (sch == rts_pkg::RTS_SCH_RPL)  ? rp_cnt : 1'b0;
  // [RQ22] Sampling enable bit gates the counter
  wire smp_on = sen_q[rts_pkg::RTS_SEN_PRECISE] &
                cfg4_q[rts_pkg::RTS_CFG_ENABLE];
  wire ctr_inc = smp_on & sch_ev & ~wr_busy;
  wire ovf     = ctr_inc & (ctr4_q == rts_pkg::RTS_CTR_MAX);
  // [RQ18] Linear buffer, no record past the limit
  wire [31:0] next_index = index_q + rts_pkg::RTS_REC_BYTES;
  wire room    = (next_index <= absmax_q);
  wire rec_go  = ovf & room;
  // [RQ24] Threshold compared with the advanced index
  wire irq_set = wr_done & (next_index >= thresh_q);
  wire irq_clr = w_status & pwdata[rts_pkg::RTS_ST_IRQ];
  // [RQ23] Store facility shut off by core events
  wire ds_off  = smm_enter | mcheck;

  // Read mux
  always_comb begin
    rd_data = rts_pkg::RTS_RST_ZERO;
    rd_err  = 1'b0;
    case (paddr)
      // [RQ20] Store facility present
      rts_pkg::RTS_OFS_ID: rd_data[rts_pkg::RTS_ID_STORE_BIT] = 1'b1;
      // [RQ21] Absent flag reads clear
      rts_pkg::RTS_OFS_MISC:   rd_data = rts_pkg::RTS_RST_ZERO;
      rts_pkg::RTS_OFS_SEN:    rd_data = sen_q;
      rts_pkg::RTS_OFS_MATRIX: rd_data = matrix_q;
      rts_pkg::RTS_OFS_TCSEL:  rd_data = tcsel_q;
      rts_pkg::RTS_OFS_UPSEL:  rd_data = upsel_q;
      rts_pkg::RTS_OFS_DNSEL:  rd_data = dnsel_q;
      rts_pkg::RTS_OFS_FESEL:  rd_data = fesel_q;
      rts_pkg::RTS_OFS_CFG4:   rd_data = cfg4_q;
      rts_pkg::RTS_OFS_CTR4:   rd_data = ctr4_q;
      rts_pkg::RTS_OFS_RELOAD: rd_data = reload_q;
      rts_pkg::RTS_OFS_AREA:   rd_data = area_q;
      rts_pkg::RTS_OFS_INDEX:  rd_data = index_q;
      rts_pkg::RTS_OFS_THRESH: rd_data = thresh_q;
      rts_pkg::RTS_OFS_ABSMAX: rd_data = absmax_q;
      rts_pkg::RTS_OFS_STATUS: begin
        rd_data[rts_pkg::RTS_ST_IRQ]  = irq_q;
        rd_data[rts_pkg::RTS_ST_BUSY] = wr_busy;
        rd_data[rts_pkg::RTS_ST_FULL] = full_q;
      end
      rts_pkg::RTS_OFS_CNT_FE: rd_data = cnt_fe_q;
      rts_pkg::RTS_OFS_CNT_EX: rd_data = cnt_ex_q;
      rts_pkg::RTS_OFS_CNT_RP: rd_data = cnt_rp_q;
      rts_pkg::RTS_OFS_CNT_IN: rd_data = cnt_in_q;
      rts_pkg::RTS_OFS_CNT_UO: rd_data = cnt_uo_q;
      default: rd_err = 1'b1;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= rts_pkg::RTS_RST_ZERO;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc & rd_err;
      prdata  <= (acc & ~pwrite) ? rd_data : rts_pkg::RTS_RST_ZERO;
    end
  end

  // Marking configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      matrix_q <= rts_pkg::RTS_RST_ZERO;
      tcsel_q  <= rts_pkg::RTS_RST_ZERO;
      upsel_q  <= rts_pkg::RTS_RST_ZERO;
      dnsel_q  <= rts_pkg::RTS_RST_ZERO;
      fesel_q  <= rts_pkg::RTS_RST_ZERO;
      cfg4_q   <= rts_pkg::RTS_RST_ZERO;
      reload_q <= rts_pkg::RTS_RST_ZERO;
    end else begin
      if (w_matrix) matrix_q <= pwdata;
      if (w_tcsel)  tcsel_q  <= pwdata;
      if (w_upsel)  upsel_q  <= pwdata;
      if (w_dnsel)  dnsel_q  <= pwdata;
      if (w_fesel)  fesel_q  <= pwdata;
      if (w_cfg4)   cfg4_q   <= pwdata;
      if (w_reload) reload_q <= pwdata;
    end
  end

  // Store facility registers, cleared by init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sen_q    <= rts_pkg::RTS_RST_ZERO;
      area_q   <= rts_pkg::RTS_RST_ZERO;
      thresh_q <= rts_pkg::RTS_RST_ZERO;
      absmax_q <= rts_pkg::RTS_RST_ZERO;
    end else if (init_req) begin
      sen_q    <= rts_pkg::RTS_RST_ZERO;
      area_q   <= rts_pkg::RTS_RST_ZERO;
      thresh_q <= rts_pkg::RTS_RST_ZERO;
      absmax_q <= rts_pkg::RTS_RST_ZERO;
    end else begin
      if (w_sen)    sen_q    <= pwdata;
      // [RQ23] Disable precise sampling
      if (ds_off)   sen_q[rts_pkg::RTS_SEN_PRECISE] <= 1'b0;
      if (w_area)   area_q   <= pwdata;
      if (w_thresh) thresh_q <= pwdata;
      if (w_absmax) absmax_q <= pwdata;
    end
  end

  // Sampling counter, index and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctr4_q  <= rts_pkg::RTS_RST_ZERO;
      index_q <= rts_pkg::RTS_RST_ZERO;
      irq_q   <= 1'b0;
      full_q  <= 1'b0;
      buf_irq <= 1'b0;
    end else if (init_req) begin
      ctr4_q  <= rts_pkg::RTS_RST_ZERO;
      index_q <= rts_pkg::RTS_RST_ZERO;
      irq_q   <= 1'b0;
      full_q  <= 1'b0;
      buf_irq <= 1'b0;
    end else begin
      if (w_ctr4) ctr4_q <= pwdata;
      if (ctr_inc) ctr4_q <= ctr4_q + 32'h0000_0001;
      // [RQ17] Reload after the record is written
      if (wr_done | (ovf & ~room)) ctr4_q <= reload_q;
      if (w_index) index_q <= pwdata;
      // [RQ24] Advance index by one record
      if (wr_done) index_q <= next_index;
      // [RQ18] Nearly full, set wins over clear
      irq_q   <= irq_set | (irq_q & ~irq_clr);
      buf_irq <= irq_set | (irq_q & ~irq_clr);
      full_q  <= (ovf & ~room) |
                 (full_q & ~(w_status & pwdata[rts_pkg::RTS_ST_FULL]));
    end
  end

  // Retirement counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_fe_q <= rts_pkg::RTS_RST_ZERO;
      cnt_ex_q <= rts_pkg::RTS_RST_ZERO;
      cnt_rp_q <= rts_pkg::RTS_RST_ZERO;
      cnt_in_q <= rts_pkg::RTS_RST_ZERO;
      cnt_uo_q <= rts_pkg::RTS_RST_ZERO;
    end else begin
      // [RQ4] Separate detector per scheme
      // [RQ10] Increase by one per counted retire
      cnt_fe_q <= cnt_fe_q + {31'h0, fe_cnt};
      cnt_ex_q <= cnt_ex_q + {31'h0, ex_cnt};
      cnt_rp_q <= cnt_rp_q + {31'h0, rp_cnt};
      cnt_in_q <= cnt_in_q + {31'h0, in_cnt};
      cnt_uo_q <= cnt_uo_q + {31'h0, uo_cnt};
    end
  end

  // [RQ16] Record of GPRs, flags and pointer
  rts_rec_writer u_writer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (rec_go),
    .base_addr (area_q + index_q),
    .busy      (wr_busy),
    .done      (wr_done),
    .gpr_flat  (gpr_flat),
    .flags     (arith_flags),
    .ip        (instr_ptr),
    .mem_valid (mem_valid),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ready (mem_ready)
  );
endmodule : rts_top

// *** logic/rts_pkg.sv ***
// Constants for the retirement tagging and precise sampling block.
// Assumes a 32-bit APB register bus and a word-wide record memory port.
package rts_pkg;
  // Register byte offsets
  localparam logic [7:0] RTS_OFS_ID     = 8'h00;
  localparam logic [7:0] RTS_OFS_MISC   = 8'h04;
  localparam logic [7:0] RTS_OFS_SEN    = 8'h08;
  localparam logic [7:0] RTS_OFS_MATRIX = 8'h0c;
  localparam logic [7:0] RTS_OFS_TCSEL  = 8'h10;
  localparam logic [7:0] RTS_OFS_UPSEL  = 8'h14;
  localparam logic [7:0] RTS_OFS_DNSEL  = 8'h18;
  localparam logic [7:0] RTS_OFS_FESEL  = 8'h1c;
  localparam logic [7:0] RTS_OFS_CFG4   = 8'h20;
  localparam logic [7:0] RTS_OFS_CTR4   = 8'h24;
  localparam logic [7:0] RTS_OFS_RELOAD = 8'h28;
  localparam logic [7:0] RTS_OFS_AREA   = 8'h2c;
  localparam logic [7:0] RTS_OFS_INDEX  = 8'h30;
  localparam logic [7:0] RTS_OFS_THRESH = 8'h34;
  localparam logic [7:0] RTS_OFS_ABSMAX = 8'h38;
  localparam logic [7:0] RTS_OFS_STATUS = 8'h3c;
  localparam logic [7:0] RTS_OFS_CNT_FE = 8'h40;
  localparam logic [7:0] RTS_OFS_CNT_EX = 8'h44;
  localparam logic [7:0] RTS_OFS_CNT_RP = 8'h48;
  localparam logic [7:0] RTS_OFS_CNT_IN = 8'h4c;
  localparam logic [7:0] RTS_OFS_CNT_UO = 8'h50;
  // Field positions
  localparam int RTS_ID_STORE_BIT   = 21;
  localparam int RTS_MISC_ABSENT    = 12;
  localparam int RTS_SEN_PRECISE    = 24;
  localparam int RTS_SEN_ALT        = 25;
  localparam int RTS_ESC_TAG_EN     = 4;
  localparam int RTS_ESC_TAG_LO     = 5;
  localparam int RTS_ESC_MASK_LO    = 9;
  localparam int RTS_ESC_SEL_LO     = 25;
  localparam int RTS_CFG_ENABLE     = 12;
  localparam int RTS_ST_IRQ         = 0;
  localparam int RTS_ST_BUSY        = 1;
  localparam int RTS_ST_FULL        = 2;
  // Reset value and counter limit
  localparam logic [31:0] RTS_RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RTS_CTR_MAX  = 32'hffff_ffff;
  // Record layout: 8 GPRs, flags, instruction pointer
  localparam int          RTS_REC_WORDS = 10;
  localparam logic [31:0] RTS_REC_BYTES = 32'h0000_0028;
  // Sampling scheme select for queue counter four
  localparam logic [1:0] RTS_SCH_FE   = 2'h0;
  localparam logic [1:0] RTS_SCH_EXEC = 2'h1;
  localparam logic [1:0] RTS_SCH_RPL  = 2'h2;
  // Record writer states
  typedef enum logic [2:0] {
    RTS_W_IDLE = 3'b001,
    RTS_W_SEND = 3'b010,
    RTS_W_DONE = 3'b100
  } rts_wstate_t;
endpackage : rts_pkg

// *** logic/rts_rec_writer.sv ***
// Writes one precise sampling record into the record buffer memory.
// Assumes a valid/ready word write port on the same clock.
`timescale 1ns/10ps
module rts_rec_writer (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         start,
  input  wire logic [31:0]  base_addr,
  output logic              busy,
  output logic              done,
  // Snapshot
  input  wire logic [255:0] gpr_flat,
  input  wire logic [31:0]  flags,
  input  wire logic [31:0]  ip,
  // Memory port
  output logic              mem_valid,
  output logic [31:0]       mem_addr,
  output logic [31:0]       mem_wdata,
  input  wire logic         mem_ready
);
  rts_pkg::rts_wstate_t state_q;
  logic [31:0] rec_q [rts_pkg::RTS_REC_WORDS];
  logic [3:0]  idx_q;
  wire         last = (idx_q == 4'(rts_pkg::RTS_REC_WORDS - 1));
  wire         beat = mem_valid & mem_ready;

  // Snapshot capture of architectural state
  always_ff @(posedge pclk) begin
    if (start && state_q == rts_pkg::RTS_W_IDLE) begin
      for (int i = 0; i < 8; i++) begin
        rec_q[i] <= gpr_flat[i*32 +: 32];
      end
      rec_q[8] <= flags;
      rec_q[9] <= ip;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= rts_pkg::RTS_W_IDLE;
      idx_q     <= 4'h0;
      busy      <= 1'b0;
      done      <= 1'b0;
      mem_valid <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else begin
      done <= 1'b0;
      case (state_q)
        rts_pkg::RTS_W_IDLE: begin
          if (start) begin
            state_q  <= rts_pkg::RTS_W_SEND;
            idx_q    <= 4'h0;
            busy     <= 1'b1;
            mem_addr <= base_addr;
          end
        end
        rts_pkg::RTS_W_SEND: begin
          mem_valid <= ~(beat & last);
          mem_wdata <= rec_q[idx_q];
          if (beat) begin
            mem_wdata <= rec_q[4'(idx_q + 4'h1)];
            mem_addr  <= mem_addr + 32'h0000_0004;
            idx_q     <= idx_q + 4'h1;
            if (last) begin
              state_q <= rts_pkg::RTS_W_DONE;
            end
          end
        end
        rts_pkg::RTS_W_DONE: begin
          state_q <= rts_pkg::RTS_W_IDLE;
          busy    <= 1'b0;
          done    <= 1'b1;
        end
        default: begin
          state_q <= rts_pkg::RTS_W_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end
endmodule : rts_rec_writer

// *** testbench/rts_checker.sv ***
// Concurrent checks on the sampler's bus, record and interrupt ports.
// Assumes one clock domain, pclk, and active-low asynchronous presetn.
`timescale 1ns/10ps
module rts_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Core events
  input wire logic        init_req,
  // Record memory and interrupt
  input wire logic        mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ready,
  input wire logic        buf_irq
);
  logic [3:0]  beat_q;
  logic [3:0]  idle_q;
  logic [31:0] addr_q;
  wire         beat  = mem_valid && mem_ready;
  wire         clr_w = psel && penable && pready && pwrite && pwdata[0] &&
                       paddr == rts_pkg::RTS_OFS_STATUS;
  // Beat count, last address, cycles since a beat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      beat_q <= 4'h0;
      addr_q <= 32'h0;
      idle_q <= 4'hf;
    end else begin
      if (beat) begin
        beat_q <= (beat_q == 4'h9) ? 4'h0 : beat_q + 4'h1;
        addr_q <= mem_addr;
      end
      idle_q <= beat ? 4'h0 : ((idle_q == 4'hf) ? idle_q : idle_q + 4'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_last_beat;
    beat && beat_q == 4'h9;
  endsequence
  AST_APB_WAIT: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready missing after one wait state");
  AST_READY_ALONE: assert property (pready |->
    psel && penable && $past(penable) && !$past(pready))
    else $error("pready outside the second access cycle");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside an answer");
  AST_UNMAPPED: assert property (pready && paddr > 8'h50 |-> pslverr)
    else $error("unmapped access without error");
  AST_IRQ_HOLD: assert property (buf_irq && !clr_w && !init_req |=>
    buf_irq)
    else $error("buffer interrupt dropped without clear");
  AST_IRQ_AFTER_REC: assert property ($rose(buf_irq) |->
    idle_q >= 4'h1 && idle_q <= 4'h8)
    else $error("buffer interrupt not tied to a finished record");
  AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=>
    mem_valid && $stable(mem_addr) && $stable(mem_wdata))
    else $error("record word changed before accepted");
  AST_ADDR_STEP: assert property (mem_valid && beat_q != 4'h0 |->
    mem_addr == addr_q + 32'h4)
    else $error("record word address not one word on");
  AST_TEN_WORDS: assert property (s_last_beat |=> !mem_valid [*2])
    else $error("record longer than ten words");
endmodule : rts_checker

// *** testbench/rts_mem_model.sv ***
// Record buffer memory at the far side of the sampler's write port.
// Assumes word writes on pclk; slow mode answers every other cycle.
`timescale 1ns/10ps
module rts_mem_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Record memory
  input  wire logic        mem_valid,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ready,
  // Pace control
  input  wire logic        slow
);
  logic [31:0] mem [0:63];
  int          beats;
  logic        ph_q;
  assign mem_ready = slow ? ph_q : 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q  <= 1'b0;
      beats <= 0;
    end else begin
      ph_q <= ~ph_q;
      if (mem_valid && mem_ready) begin
        mem[mem_addr[7:2]] <= mem_wdata;
        beats              <= beats + 1;
      end
    end
  end
endmodule : rts_mem_model

// *** testbench/rts_top_test.sv ***
// Self-checking bench for the retirement tagging sampler.
// Assumes rts_pkg, rts_top, rts_mem_model and rts_checker are compiled.
`timescale 1ns/10ps
module rts_top_test;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rdata_v, arith_flags, instr_ptr;
  logic         ret_valid, ret_bogus, ret_instr_end, ret_no_mark;
  logic         ret_fe_event, ret_mispredict, smm_enter, init_req, mcheck;
  logic [5:0]   ret_exec_class;
  logic [15:0]  ret_exec_mask;
  logic [7:0]   ret_replay_kind, ret_uop_type;
  logic [255:0] gpr_flat;
  logic [31:0]  mem_addr, mem_wdata;
  logic         mem_valid, mem_ready, buf_irq, err_v, slow;
  int           num_errors, checks_done, cycles;

  rts_top rts_top_i (.*);
  rts_mem_model rts_mem_model_i (.*);

  always #2.5 pclk = ~pclk;
  // Hang guard
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdata_v = prdata;
    err_v   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata_v, exp);
  endtask : rc

  // Flags: 0 front-end, 1 cancelled, 2 unmarkable, 3 mispredict, 4 end
  task automatic ret(input logic [4:0] f);
    ret_fe_event   <= f[0];
    ret_bogus      <= f[1];
    ret_no_mark    <= f[2];
    ret_mispredict <= f[3];
    ret_instr_end  <= f[4];
    ret_valid      <= 1'b1;
    @(posedge pclk);
    ret_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : ret

  initial begin
    {pclk, psel, penable, pwrite, ret_valid, ret_bogus, ret_no_mark} = '0;
    {ret_instr_end, ret_fe_event, ret_mispredict, smm_enter, mcheck} = '0;
    {init_req, slow, paddr, pwdata, ret_exec_class, ret_exec_mask} = '0;
    {ret_replay_kind, ret_uop_type, num_errors, checks_done, cycles} = '0;
    for (int i = 0; i < 8; i++) gpr_flat[32*i+:32] = 32'h1111_0000 + 32'(i);
    arith_flags = 32'h0000_0246;
    instr_ptr   = 32'h0040_1000;
    presetn     = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(rts_pkg::RTS_OFS_ID, 32'h0020_0000);
    rc(rts_pkg::RTS_OFS_MISC, 32'h0);
    apb(1'b0, 8'h54, 32'h0);
    chk({31'h0, err_v}, 32'h1);
    // Unmarked counting
    ret(5'h10);
    ret(5'h00);
    ret(5'h02);
    rc(rts_pkg::RTS_OFS_CNT_IN, 32'h1);
    rc(rts_pkg::RTS_OFS_CNT_UO, 32'h2);
    // Front-end marking
    wr(rts_pkg::RTS_OFS_FESEL, 32'h1);
    ret(5'h01);
    ret(5'h05);
    ret(5'h03);
    rc(rts_pkg::RTS_OFS_CNT_FE, 32'h1);
    rc(rts_pkg::RTS_OFS_CNT_EX, 32'h0);
    rc(rts_pkg::RTS_OFS_CNT_RP, 32'h0);
    // Execution marking, tag value 3
    wr(rts_pkg::RTS_OFS_UPSEL, 32'h0a00_0270);
    wr(rts_pkg::RTS_OFS_DNSEL, 32'h0000_03f0);
    ret_exec_class <= 6'h05;
    ret_exec_mask  <= 16'h0001;
    ret(5'h00);
    rc(rts_pkg::RTS_OFS_CNT_EX, 32'h1);
    ret_exec_class <= 6'h06;
    ret(5'h00);
    rc(rts_pkg::RTS_OFS_CNT_EX, 32'h1);
    ret_exec_class <= 6'h05;
    wr(rts_pkg::RTS_OFS_DNSEL, 32'h0000_0400);
    ret(5'h00);
    rc(rts_pkg::RTS_OFS_CNT_EX, 32'h2);
    wr(rts_pkg::RTS_OFS_UPSEL, 32'h0a00_0260);
    ret(5'h00);
    rc(rts_pkg::RTS_OFS_CNT_EX, 32'h2);
    rc(rts_pkg::RTS_OFS_CNT_FE, 32'h1);
    // Replay marking without precise sampling
    ret_exec_class <= 6'h00;
    wr(rts_pkg::RTS_OFS_SEN, 32'h0000_0001);
    wr(rts_pkg::RTS_OFS_MATRIX, 32'h0000_0001);
    ret_replay_kind <= 8'h01;
    ret_uop_type    <= 8'h01;
    ret(5'h00);
    ret_uop_type <= 8'h02;
    ret(5'h00);
    ret(5'h08);
    rc(rts_pkg::RTS_OFS_CNT_RP, 32'h2);
    rc(rts_pkg::RTS_OFS_CNT_EX, 32'h2);
    // Precise sampling with a slow memory
    slow <= 1'b1;
    wr(rts_pkg::RTS_OFS_AREA, 32'h0000_1000);
    wr(rts_pkg::RTS_OFS_THRESH, 32'h0000_0028);
    wr(rts_pkg::RTS_OFS_ABSMAX, 32'h0000_00c8);
    wr(rts_pkg::RTS_OFS_RELOAD, 32'hffff_fffe);
    wr(rts_pkg::RTS_OFS_CTR4, 32'hffff_fffe);
    wr(rts_pkg::RTS_OFS_CFG4, 32'h0000_1000);
    wr(rts_pkg::RTS_OFS_SEN, 32'h0100_0001);
    rc(rts_pkg::RTS_OFS_SEN, 32'h0100_0001);
    ret(5'h01);
    ret(5'h01);
    while (rts_mem_model_i.beats < 10) @(posedge pclk);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      chk(rts_mem_model_i.mem[i], (i < 8) ? gpr_flat[32*i+:32] :
          ((i == 8) ? arith_flags : instr_ptr));
    end
    rc(rts_pkg::RTS_OFS_INDEX, 32'h0000_0028);
    rc(rts_pkg::RTS_OFS_CTR4, 32'hffff_fffe);
    chk({31'h0, buf_irq}, 32'h1);
    wr(rts_pkg::RTS_OFS_STATUS, 32'h0000_0001);
    rc(rts_pkg::RTS_OFS_STATUS, 32'h0);
    chk({31'h0, buf_irq}, 32'h0);
    // Buffer would pass its end: no record, full flag
    wr(rts_pkg::RTS_OFS_ABSMAX, 32'h0000_0040);
    ret(5'h01);
    ret(5'h01);
    repeat (8) @(posedge pclk);
    chk(32'(rts_mem_model_i.beats), 32'h0000_000a);
    rc(rts_pkg::RTS_OFS_STATUS, 32'h0000_0004);
    rc(rts_pkg::RTS_OFS_CTR4, 32'hffff_fffe);
    // No sampling outside the three marked schemes
    wr(rts_pkg::RTS_OFS_CFG4, 32'h0000_1003);
    ret(5'h01);
    rc(rts_pkg::RTS_OFS_CTR4, 32'hffff_fffe);
    // Replay scheme feeds the sampling counter
    wr(rts_pkg::RTS_OFS_CFG4, 32'h0000_1002);
    ret(5'h08);
    rc(rts_pkg::RTS_OFS_CTR4, 32'hffff_ffff);
    // Management mode, machine check and init
    smm_enter <= 1'b1;
    @(posedge pclk);
    smm_enter <= 1'b0;
    @(posedge pclk);
    rc(rts_pkg::RTS_OFS_SEN, 32'h0000_0001);
    wr(rts_pkg::RTS_OFS_SEN, 32'h0100_0001);
    mcheck <= 1'b1;
    @(posedge pclk);
    mcheck <= 1'b0;
    @(posedge pclk);
    rc(rts_pkg::RTS_OFS_SEN, 32'h0000_0001);
    init_req <= 1'b1;
    @(posedge pclk);
    init_req <= 1'b0;
    @(posedge pclk);
    rc(rts_pkg::RTS_OFS_AREA, 32'h0);
    stop_test();
  end
endmodule : rts_top_test

bind rts_top rts_checker rts_checker_i (.*);
